// ### logic/ipa_cfg.svh
`ifndef IPA_CFG_SVH
`define IPA_CFG_SVH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define IPA_NUM_IRQ        240
`define IPA_NUM_BANK_WORDS 8
`define IPA_NUM_PRIO_WORDS 60
`define IPA_PRIO_BITS      4
`define IPA_ADDR_W         12

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define IPA_OFS_PEND_SET   12'h200
`define IPA_OFS_PEND_CLR   12'h280
`define IPA_OFS_ACTIVE     12'h300
`define IPA_OFS_PRIO       12'h400
`define IPA_OFS_CTRL       12'hd00
`define IPA_OFS_TRIGGER    12'he00

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define IPA_TRIG_ID_MSB    8
`define IPA_CTRL_UNPRIV    0
`define IPA_PRIO_LSB       4
`define IPA_RESET_WORD     32'h0000_0000

`endif

// ### logic/ipa_pkg.sv
package ipa_pkg;

    // apb answer sequencer: idle waits for the first access cycle, answer holds pready high
    typedef enum logic {
        IPA_ST_IDLE   = 1'b0,
        IPA_ST_ANSWER = 1'b1
    } ipa_apb_st_t;

    typedef logic [7:0] ipa_irq_num_t;

endpackage : ipa_pkg

// ### logic/ipa_top.sv
// Our own choice: the APB register port.
`timescale 1ns/1ns
`include "ipa_cfg.svh"

module ipa_top (
    input  wire logic                          i_core_clk,      // 125 MHz core clock
    input  wire logic                          i_reset,         // async reset, active high
    input  wire logic                          psel,            // apb select
    input  wire logic                          penable,         // apb access phase
    input  wire logic                          pwrite,          // apb direction
    input  wire logic [`IPA_ADDR_W-1:0]        paddr,           // apb byte address
    input  wire logic [31:0]                   pwdata,          // apb write data
    input  wire logic [3:0]                    pstrb,           // apb byte strobes
    input  wire logic [2:0]                    pprot,           // bit0 high = privileged
    output logic      [31:0]                   prdata,          // apb read data
    output logic                               pready,          // apb ready
    output logic                               pslverr,         // apb error
    input  wire logic [`IPA_NUM_IRQ-1:0]       i_irq_req,       // peripheral request pins
    input  wire logic [`IPA_NUM_IRQ-1:0]       i_irq_enable,    // enable bits from enable bank
    input  wire logic                          i_entry,         // handler entry pulse
    input  wire logic [7:0]                    i_entry_num,     // irq entered
    input  wire logic                          i_return,        // handler return pulse
    input  wire logic [7:0]                    i_return_num,    // irq returned from
    output logic                               o_sel_valid,     // a candidate is ready
    output logic [7:0]                         o_sel_num,       // candidate irq number
    output logic [`IPA_PRIO_BITS-1:0]          o_sel_prio       // candidate priority
);

    // ---------------------------------------------------------------
    // timing summary
    // ---------------------------------------------------------------
    // bus side:
    //   edge 1: setup seen, nothing happens yet
    //   edge 2: first access edge, decode and read data captured
    //   edge 3: pready high, a write takes effect here only
    //   pready, pslverr and prdata stand for exactly one cycle
    //   prdata returns to zero so stale words never leak
    // refusals:
    //   unprivileged access to any bank or the control word
    //   unprivileged trigger while the allow bit is clear
    //   misaligned or unmapped addresses, priority word 60 and up
    //   a refused write changes nothing, a refused read gives zero
    // request side:
    //   pin to s1, s1 to s2, s2 into pending: three edges
    //   candidate outputs follow pending by one more edge
    //   edge history starts low so reset gives no false edge
    // handler side:
    //   entry and return are single-cycle events on this clock
    //   entry clears pending and sets active in one edge
    //   return clears active; a high level re-arms pending
    //   a pulse during the handler re-arms pending only
    // trade-offs:
    //   selection is one flat loop over all irqs, registered
    //   so the long compare chain ends in a flip-flop
    //   no grouping or preemption here; the core decides that
    //   ids above the last irq are dropped without an error
    // hazards:
    //   set terms beat clear terms in the same cycle
    //   the level term is masked in the entry cycle,
    //   otherwise a held level could never be cleared by entry
    //   enables arrive on this clock and are not synchronised

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    localparam int NI = `IPA_NUM_IRQ;

    ipa_pkg::ipa_apb_st_t               st_q;
    logic [NI-1:0]                      req_s1_q;
    logic [NI-1:0]                      req_s2_q;
    logic [NI-1:0]                      req_prev_q;
    logic [NI-1:0]                      pend_q;
    logic [NI-1:0]                      pend_d;
    logic [NI-1:0]                      act_q;
    logic [NI-1:0]                      act_d;
    logic [`IPA_PRIO_BITS-1:0]          prio_q [NI];
    logic                               unpriv_q;
    logic [31:0]                        rdata_q;
    logic                               ready_q;
    logic                               err_q;
    logic                               sel_valid_q;
    ipa_pkg::ipa_irq_num_t              sel_num_q;
    logic [`IPA_PRIO_BITS-1:0]          sel_prio_q;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    // one 32-bit bank word out of a per-irq vector; missing irqs read zero
    function automatic logic [31:0] bank_word(input logic [NI-1:0] v, input logic [2:0] w);
        logic [255:0] wide;
        wide = {16'h0000, v};
        return wide[{w, 5'h00} +: 32];
    endfunction : bank_word

    // a write pattern gated by byte strobes
    function automatic logic [31:0] strobe_mask(input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return d & m;
    endfunction : strobe_mask

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    logic        priv;
    logic        hit_set;
    logic        hit_clr;
    logic        hit_act;
    logic        hit_prio;
    logic        hit_ctrl;
    logic        hit_trig;
    logic        acc_err;
    logic [2:0]  bank_w;
    logic [5:0]  prio_w;

    // banks span eight words each; priority words stop at 60
    always_comb begin
        priv     = pprot[0];
        bank_w   = paddr[4:2];
        prio_w   = paddr[7:2];
        hit_set  = (paddr[11:5] == `IPA_OFS_PEND_SET >> 5) && (paddr[1:0] == 2'h0);
        hit_clr  = (paddr[11:5] == `IPA_OFS_PEND_CLR >> 5) && (paddr[1:0] == 2'h0);
        hit_act  = (paddr[11:5] == `IPA_OFS_ACTIVE >> 5) && (paddr[1:0] == 2'h0);
        hit_prio = (paddr[11:8] == `IPA_OFS_PRIO >> 8) && (paddr[1:0] == 2'h0)
                   && (prio_w < 6'(`IPA_NUM_PRIO_WORDS));
        hit_ctrl = (paddr == `IPA_OFS_CTRL);
        hit_trig = (paddr == `IPA_OFS_TRIGGER);
        // unprivileged software may only reach the trigger, and only when allowed
        acc_err  = 1'b0;
        if (hit_set || hit_clr || hit_act || hit_prio || hit_ctrl) begin
            acc_err = !priv;
        end else if (hit_trig) begin
            acc_err = !priv && !unpriv_q;
        end else begin
            acc_err = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // apb answer sequencer
    // ---------------------------------------------------------------
    logic wr_go;
    logic rd_take;

    // pready rises in the second access cycle, so every transfer takes
    // setup plus two access cycles; writes act only at the completing edge
    assign rd_take = (st_q == ipa_pkg::IPA_ST_IDLE) && psel && penable;
    assign wr_go   = (st_q == ipa_pkg::IPA_ST_ANSWER) && psel && penable && pwrite && !err_q;

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q    <= ipa_pkg::IPA_ST_IDLE;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            case (st_q)
                ipa_pkg::IPA_ST_IDLE: begin
                    if (rd_take) begin
                        st_q    <= ipa_pkg::IPA_ST_ANSWER;
                        ready_q <= 1'b1;
                        err_q   <= acc_err;
                    end
                end
                ipa_pkg::IPA_ST_ANSWER: begin
                    st_q    <= ipa_pkg::IPA_ST_IDLE;
                    ready_q <= 1'b0;
                    err_q   <= 1'b0;
                end
                default: begin
                    st_q    <= ipa_pkg::IPA_ST_IDLE;
                    ready_q <= 1'b0;
                    err_q   <= 1'b0;
                end
            endcase
        end
    end

    // read data captured with pready; stays zero on writes and errors
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= `IPA_RESET_WORD;
        end else if (rd_take && !pwrite && !acc_err) begin
            if (hit_set || hit_clr) begin
                rdata_q <= bank_word(pend_q, bank_w);
            end else if (hit_act) begin
                rdata_q <= bank_word(act_q, bank_w);
            end else if (hit_prio) begin
                for (int b = 0; b < 4; b++) begin
                    rdata_q[b*8 +: 8] <= {prio_q[{prio_w, 2'(b)}], 4'h0};
                end
            end else if (hit_ctrl) begin
                rdata_q <= {31'h0, unpriv_q};
            end else begin
                rdata_q <= `IPA_RESET_WORD;                     // trigger is write only
            end
        end else if (rd_take || ready_q) begin
            rdata_q <= `IPA_RESET_WORD;
        end
    end

    // ---------------------------------------------------------------
    // control register and priority store
    // ---------------------------------------------------------------
    // permission bit lives here; the decode already refuses unprivileged writes
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            unpriv_q <= 1'b0;
        end else if (wr_go && hit_ctrl && pstrb[0]) begin
            unpriv_q <= pwdata[`IPA_CTRL_UNPRIV];
        end
    end

    // byte lane b of word w is field 4w+b; low nibble never stored
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int n = 0; n < NI; n++) begin
                prio_q[n] <= '0;
            end
        end else if (wr_go && hit_prio) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    prio_q[{prio_w, 2'(b)}] <= pwdata[b*8+`IPA_PRIO_LSB +: 4];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // request synchronisers
    // ---------------------------------------------------------------
    // pins are asynchronous; s1 feeds only s2, prev gives the edge history
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            req_s1_q   <= '0;
            req_s2_q   <= '0;
            req_prev_q <= '0;
        end else begin
            req_s1_q   <= i_irq_req;
            req_s2_q   <= req_s1_q;
            req_prev_q <= req_s2_q;
        end
    end

    // ---------------------------------------------------------------
    // pending and active next state
    // ---------------------------------------------------------------
    logic [31:0] set_pat;
    logic [31:0] clr_pat;
    logic [8:0]  trig_id;
    logic        s_set;
    logic        s_clr;
    logic        s_trig;
    logic        s_entry;
    logic        s_ret;
    logic        s_rise;
    logic        s_level;

    // set terms win over clear terms so no event is lost in a clear cycle
    always_comb begin
        set_pat = strobe_mask(pwdata, pstrb);
        clr_pat = strobe_mask(pwdata, pstrb);
        trig_id = pwdata[`IPA_TRIG_ID_MSB:0];
        pend_d  = pend_q;
        act_d   = act_q;
        for (int i = 0; i < NI; i++) begin
            s_set   = wr_go && hit_set && (bank_w == 3'(i / 32)) && set_pat[i % 32];
            s_clr   = wr_go && hit_clr && (bank_w == 3'(i / 32)) && clr_pat[i % 32];
            s_trig  = wr_go && hit_trig && (trig_id == 9'(i));
            s_entry = i_entry && (i_entry_num == 8'(i));
            s_ret   = i_return && (i_return_num == 8'(i));
            s_rise  = req_s2_q[i] && !req_prev_q[i];
            // level term held off in the entry cycle, else entry could not clear
            s_level = req_s2_q[i] && !act_q[i] && !s_entry;
            if (s_set || s_trig || s_rise || s_level
                || (s_ret && req_s2_q[i])) begin
                pend_d[i] = 1'b1;
            end else if (s_clr || s_entry) begin
                pend_d[i] = 1'b0;
            end
            // only entry and return move the active flag
            if (s_entry) begin
                act_d[i] = 1'b1;
            end else if (s_ret) begin
                act_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            pend_q <= '0;
            act_q  <= '0;
        end else begin
            pend_q <= pend_d;
            act_q  <= act_d;
        end
    end

    // ---------------------------------------------------------------
    // candidate selection
    // ---------------------------------------------------------------
    logic                      best_valid;
    ipa_pkg::ipa_irq_num_t     best_num;
    logic [`IPA_PRIO_BITS-1:0] best_prio;

    // a long compare chain; fine at 125 MHz only because the result is
    // registered and nothing else sits in the path
    always_comb begin
        best_valid = 1'b0;
        best_num   = '0;
        best_prio  = '1;
        for (int i = 0; i < NI; i++) begin
            // disabled or already running irqs are never offered
            if (pend_q[i] && i_irq_enable[i] && !act_q[i]) begin
                // strict compare keeps the lowest number on a tie
                if (!best_valid || (prio_q[i] < best_prio)) begin
                    best_valid = 1'b1;
                    best_num   = 8'(i);
                    best_prio  = prio_q[i];
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            sel_valid_q <= 1'b0;
            sel_num_q   <= '0;
            sel_prio_q  <= '0;
        end else begin
            sel_valid_q <= best_valid;
            sel_num_q   <= best_num;
            sel_prio_q  <= best_prio;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata      = rdata_q;
    assign pready      = ready_q;
    assign pslverr     = err_q;
    assign o_sel_valid = sel_valid_q;
    assign o_sel_num   = sel_num_q;
    assign o_sel_prio  = sel_prio_q;

endmodule : ipa_top

// ### verif/ipa_monitor.sv
`timescale 1ns/1ns
`include "ipa_cfg.svh"

module ipa_monitor (
    input wire logic                    i_core_clk,   // core clock
    input wire logic                    i_reset,      // async reset
    input wire logic                    psel,         // apb select
    input wire logic                    penable,      // apb access
    input wire logic                    pwrite,       // apb direction
    input wire logic [`IPA_ADDR_W-1:0]  paddr,        // apb address
    input wire logic [2:0]              pprot,        // apb protection
    input wire logic [31:0]             prdata,       // apb read data
    input wire logic                    pready,       // apb ready
    input wire logic                    pslverr,      // apb error
    input wire logic [`IPA_NUM_IRQ-1:0] i_irq_enable, // enable bits
    input wire logic                    i_entry,      // handler entry
    input wire logic [7:0]              i_entry_num,  // entered irq
    input wire logic                    o_sel_valid,  // candidate valid
    input wire logic [7:0]              o_sel_num     // candidate number
);
    // ----------------
    // helper state
    // ----------------
    // enables one and two edges back: tolerates a registered enable path
    logic [`IPA_NUM_IRQ-1:0] en_q;
    logic [`IPA_NUM_IRQ-1:0] en_qq;

    always_ff @(posedge i_core_clk) begin
        en_q  <= i_irq_enable;
        en_qq <= en_q;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    // ----------------
    // assertions
    // ----------------
    a_reset_quiet: assert property (
        $fell(i_reset) |-> !pready && !o_sel_valid && prdata == 32'h0)
        else $error("outputs busy after reset");
    a_access_answer: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("no answer one cycle into access");
    a_ready_drop: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_unpriv_err: assert property (
        psel && penable && pready && !pprot[0] && paddr < 12'hd00 |-> pslverr)
        else $error("unprivileged bank access accepted");
    a_prio_nibble: assert property (
        pready && !pwrite && paddr[11:8] == 4'h4 |-> (prdata & 32'h0f0f0f0f) == 32'h0)
        else $error("priority low nibble not zero");
    a_trig_reads: assert property (
        pready && !pwrite && paddr == 12'he00 |-> prdata == 32'h0)
        else $error("trigger register read not zero");
    a_word7_resv: assert property (
        pready && !pwrite && paddr[6:0] == 7'h1c && paddr[11:9] == 3'h1 |-> prdata[31:16] == 0)
        else $error("reserved bank bits not zero");
    a_sel_enabled: assert property (
        o_sel_valid |-> en_q[o_sel_num] || en_qq[o_sel_num])
        else $error("disabled irq offered");
    a_entry_hides: assert property (
        i_entry |-> ##2 !(o_sel_valid && o_sel_num == $past(i_entry_num, 2)))
        else $error("entered irq still offered");

    c_sel_seen: cover property (o_sel_valid);
    c_refused: cover property (pready && pslverr);
    c_entry: cover property (i_entry ##1 !i_entry);
endmodule : ipa_monitor

bind ipa_top ipa_monitor u_mon (
    .i_core_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pprot, .prdata, .pready,
    .pslverr, .i_irq_enable, .i_entry, .i_entry_num, .o_sel_valid, .o_sel_num
);

// ### verif/ipa_core_model.sv
`timescale 1ns/1ns
`include "ipa_cfg.svh"

module ipa_core_model (
    input  wire logic                   i_core_clk,  // core clock
    output logic [`IPA_NUM_IRQ-1:0]     o_irq_req,   // request pins
    output logic                        o_entry,     // handler entry
    output logic [7:0]                  o_entry_num, // entered irq
    output logic                        o_return,    // handler return
    output logic [7:0]                  o_return_num // returned irq
);
    // ----------------
    // peripherals and core
    // ----------------
    initial begin
        o_irq_req    = '0;
        o_entry      = 1'b0;
        o_entry_num  = 8'h00;
        o_return     = 1'b0;
        o_return_num = 8'h00;
    end

    // two cycles high then two low, so the edge is never merged
    task pulse(input int n);
        @(posedge i_core_clk);
        o_irq_req[n] <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        o_irq_req[n] <= 1'b0;
        repeat (2) @(posedge i_core_clk);
    endtask : pulse

    // level stays until a later hold call changes it
    task hold(input int n, input logic v);
        @(posedge i_core_clk);
        o_irq_req[n] <= v;
        repeat (4) @(posedge i_core_clk);
    endtask : hold

    // one-cycle entry or return event
    task handler(input logic ret, input logic [7:0] n);
        @(posedge i_core_clk);
        o_entry      <= !ret;
        o_return     <= ret;
        o_entry_num  <= n;
        o_return_num <= n;
        @(posedge i_core_clk);
        o_entry      <= 1'b0;
        o_return     <= 1'b0;
        o_entry_num  <= ~n;  // unqualified: never keep a stale number
        o_return_num <= ~n;
    endtask : handler
endmodule : ipa_core_model

// ### verif/testbench.sv
`timescale 1ns/1ns
`include "ipa_cfg.svh"

module testbench;
    // ----------------
    // signals and model state
    // ----------------
    logic                    i_core_clk   = 1'b0;
    logic                    i_reset      = 1'b1;
    logic                    psel         = 1'b0;
    logic                    penable      = 1'b0;
    logic                    pwrite       = 1'b0;
    logic [11:0]             paddr        = 12'h000;
    logic [31:0]             pwdata       = 32'h0;
    logic [3:0]              pstrb        = 4'h0;
    logic [2:0]              pprot        = 3'h0;
    logic [`IPA_NUM_IRQ-1:0] i_irq_enable = '0;
    logic [`IPA_NUM_IRQ-1:0] i_irq_req;
    logic [7:0]              i_entry_num, i_return_num, o_sel_num;
    logic [31:0]             prdata, rdat;
    logic                    pready, pslverr, o_sel_valid, rerr, i_entry, i_return;
    logic [3:0]              o_sel_prio;
    bit   [255:0]            mp, ma;     // expected pending and active
    bit   [3:0]              mpr [240];  // expected priority nibbles
    int                      fails, total_checks, best, x;

    ipa_top u_dut (
        .i_core_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pprot,
        .prdata, .pready, .pslverr, .i_irq_req, .i_irq_enable, .i_entry, .i_entry_num,
        .i_return, .i_return_num, .o_sel_valid, .o_sel_num, .o_sel_prio
    );
    ipa_core_model u_core (
        .i_core_clk, .o_irq_req(i_irq_req), .o_entry(i_entry), .o_entry_num(i_entry_num),
        .o_return(i_return), .o_return_num(i_return_num)
    );

    always #4 i_core_clk = ~i_core_clk;

    // ----------------
    // tasks
    // ----------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; no fixed latency assumed, watchdog cuts a hang
    task acc(input logic w, input logic [11:0] a, input logic [31:0] dw, input logic [3:0] s,
             input logic p, input logic ee, input logic [31:0] er);
        @(posedge i_core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dw;
        pstrb   <= s;
        pprot   <= {2'b00, p};
        @(posedge i_core_clk);
        penable <= 1'b1;
        do @(posedge i_core_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, rerr}, {31'h0, ee});
        if (!w) chk(rdat, er);
    endtask : acc

    task banks();
        for (int j = 0; j < 8; j++) begin
            acc(1'b0, 12'h200 + 12'(4 * j), 32'h0, 4'hf, 1'b1, 1'b0, mp[32*j +: 32]);
            acc(1'b0, 12'h280 + 12'(4 * j), 32'h0, 4'hf, 1'b1, 1'b0, mp[32*j +: 32]);
            acc(1'b0, 12'h300 + 12'(4 * j), 32'h0, 4'hf, 1'b1, 1'b0, ma[32*j +: 32]);
        end
    endtask : banks

    task pend_wr(input int w, input logic [31:0] dw, input bit clr);
        logic [31:0] v;
        v = dw & (w == 7 ? 32'h0000ffff : 32'hffffffff);
        acc(1'b1, (clr ? 12'h280 : 12'h200) + 12'(4 * w), dw, 4'hf, 1'b1, 1'b0, 32'h0);
        mp[32*w +: 32] = clr ? mp[32*w +: 32] & ~v : mp[32*w +: 32] | v;
    endtask : pend_wr

    task prio_wr(input int w, input logic [31:0] dw, input logic [3:0] s);
        acc(1'b1, 12'h400 + 12'(4 * w), dw, s, 1'b1, 1'b0, 32'h0);
        for (int b = 0; b < 4; b++)
            if (s[b]) mpr[4*w+b] = dw[8*b+4 +: 4];
        acc(1'b0, 12'h400 + 12'(4 * w), 32'h0, 4'hf, 1'b1, 1'b0, {mpr[4*w+3], 4'h0,
            mpr[4*w+2], 4'h0, mpr[4*w+1], 4'h0, mpr[4*w], 4'h0});
    endtask : prio_wr

    // best candidate: smallest value, ties to the lowest number
    task sel();
        repeat (2) @(posedge i_core_clk);
        best = -1;
        for (int i = 0; i < 240; i++)
            if (mp[i] && i_irq_enable[i] && !ma[i] && (best < 0 || mpr[i] < mpr[best]))
                best = i;
        chk({31'h0, o_sel_valid}, {31'h0, best >= 0});
        if (best >= 0) chk({o_sel_num, o_sel_prio}, {8'(best), mpr[best]});
    endtask : sel

    task summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // ----------------
    // sequence
    // ----------------
    initial begin
        #160000;
        fails++;
        summarize();
    end

    initial begin
        void'($urandom(87));
        repeat (16) @(posedge i_core_clk);
        i_reset <= 1'b0;
        banks();
        for (int k = 0; k < 12; k++) begin
            x = $urandom_range(7);
            pend_wr(x, $urandom(), k % 3 == 2);
            pend_wr(x, $urandom(), k % 3 == 2);
        end
        banks();
        for (int k = 0; k < 8; k++)
            prio_wr(k == 0 ? 59 : k == 1 ? 0 : $urandom_range(59), $urandom(), 4'($urandom()));
        acc(1'b0, 12'h4f0, 32'h0, 4'hf, 1'b1, 1'b1, 32'h0);
        acc(1'b0, 12'h600, 32'h0, 4'hf, 1'b1, 1'b1, 32'h0);
        acc(1'b1, 12'h200, 32'hffffffff, 4'hf, 1'b0, 1'b1, 32'h0);
        acc(1'b1, 12'he00, 32'd239, 4'hf, 1'b0, 1'b1, 32'h0);
        acc(1'b1, 12'hd00, 32'h1, 4'hf, 1'b0, 1'b1, 32'h0);
        acc(1'b1, 12'hd00, 32'h1, 4'hf, 1'b1, 1'b0, 32'h0);
        acc(1'b1, 12'he00, 32'd239, 4'hf, 1'b0, 1'b0, 32'h0);
        mp[239] = 1'b1;
        x = $urandom_range(238);
        acc(1'b1, 12'he00, 32'(x), 4'hf, 1'b1, 1'b0, 32'h0);
        mp[x] = 1'b1;
        acc(1'b1, 12'he00, 32'd240, 4'hf, 1'b1, 1'b0, 32'h0);
        acc(1'b0, 12'he00, 32'h0, 4'hf, 1'b1, 1'b0, 32'h0);
        banks();
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 240; i++) i_irq_enable[i] <= k == 2 || $urandom_range(1);
            sel();
        end
        u_core.handler(1'b0, 8'(best));
        mp[best] = 1'b0;
        ma[best] = 1'b1;
        pend_wr(best / 32, 32'h1 << (best % 32), 1'b1);
        banks();
        sel();
        u_core.handler(1'b1, 8'(best));
        ma[best] = 1'b0;
        // request pins: pulse, level with handler, pulse inside handler
        for (x = 0; x < 8; x++) pend_wr(x, 32'hffffffff, 1'b1);
        u_core.pulse(10);
        mp[10] = 1'b1;
        u_core.hold(20, 1'b1);
        mp[20] = 1'b1;
        acc(1'b1, 12'h280, 32'h0010_0000, 4'hf, 1'b1, 1'b0, 32'h0);
        u_core.handler(1'b0, 8'd20);
        mp[20] = 1'b0;
        ma[20] = 1'b1;
        banks();
        u_core.handler(1'b1, 8'd20);
        mp[20] = 1'b1;
        ma[20] = 1'b0;
        banks();
        u_core.hold(20, 1'b0);
        pend_wr(0, 32'h0010_0000, 1'b1);
        u_core.pulse(30);
        u_core.handler(1'b0, 8'd30);
        u_core.pulse(30);
        mp[30] = 1'b1;
        ma[30] = 1'b1;
        banks();
        u_core.handler(1'b1, 8'd30);
        ma[30] = 1'b0;
        banks();
        summarize();
    end
endmodule : testbench
